// ===== logic/lam_monitor.sv
// Limit alert monitor: alert control and threshold registers, compare, alert pin.
// Assumes a serial slave engine that gives one-cycle read and write strobes
// and a measurement core that pulses valid once per finished averaged result.
//
// Summary of operation
// - Several limit enables set: only the highest bit position is compared.
// - Shunt over enable: alert when shunt result above threshold.
// - Shunt under enable: alert when shunt result below threshold.
// - Bus over enable: alert when bus result above threshold.
// - Bus under enable: alert when bus result below threshold.
// - Power over enable: alert when power result above threshold.
// - Conversion-ready enable: alert when done flag sets, alongside one limit.
// - Source flag set by limit alert; latched mode clears it on control read.
// - Transparent mode clears source flag after next passing conversion.
// - Done flag sets only once conversion, averaging and multiply finish.
// - Done flag clears on non power-down config write or control read.
// - Overflow flag sets when internal arithmetic overflows.
// - Polarity bit: one active-high, zero active-low open-collector alert.
// - Latch bit: one latches alert, source and overflow flags, zero is transparent.
// - Transparent returns idle when fault gone; latched holds until control read.
// - Sixteen-bit read/write threshold compared with selected result.
// - Shunt result compared as signed twos complement.
`timescale 1ns/10ps
module lam_monitor #(
    // Register word width
    parameter int unsigned DATA_W = lam_pkg::REG_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access
    input wire lam_pkg::lam_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    // Measurement results
    input wire lam_pkg::lam_result_t result,
    // Open-drain alert pin
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe
);

    lam_pkg::lam_state_t s_q;
    lam_pkg::lam_state_t s_d;
    lam_pkg::lam_sel_t sel;
    logic ctrl_rd;
    logic ctrl_wr;
    logic thr_wr;
    logic cfg_clr;
    logic hit;
    logic done_set;
    logic ovf_set;
    logic latch;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check

    // Carriers in the package are fixed at one register word
    if (DATA_W != lam_pkg::REG_W) begin : g_width_check
        $error("register width must match the package word");
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority select of the limit function

    function automatic lam_pkg::lam_sel_t pick(input logic [15:0] c);
        if (c[lam_pkg::BIT_SHUNT_OVER]) begin
            pick = lam_pkg::LAM_SEL_SHUNT_OVER;
        end else if (c[lam_pkg::BIT_SHUNT_UNDER]) begin
            pick = lam_pkg::LAM_SEL_SHUNT_UNDER;
        end else if (c[lam_pkg::BIT_BUS_OVER]) begin
            pick = lam_pkg::LAM_SEL_BUS_OVER;
        end else if (c[lam_pkg::BIT_BUS_UNDER]) begin
            pick = lam_pkg::LAM_SEL_BUS_UNDER;
        end else if (c[lam_pkg::BIT_POWER_OVER]) begin
            pick = lam_pkg::LAM_SEL_POWER_OVER;
        end else begin
            pick = lam_pkg::LAM_SEL_NONE;
        end
    endfunction

    assign sel = pick(s_q.ctrl);

    // Bus and power are unsigned; shunt is signed
    always_comb begin
        case (sel)
            lam_pkg::LAM_SEL_SHUNT_OVER: begin
                hit = $signed(result.shunt) > $signed(s_q.thresh);
            end
            lam_pkg::LAM_SEL_SHUNT_UNDER: begin
                hit = $signed(result.shunt) < $signed(s_q.thresh);
            end
            lam_pkg::LAM_SEL_BUS_OVER: begin
                hit = result.bus > s_q.thresh;
            end
            lam_pkg::LAM_SEL_BUS_UNDER: begin
                hit = result.bus < s_q.thresh;
            end
            lam_pkg::LAM_SEL_POWER_OVER: begin
                hit = result.power > s_q.thresh;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode and next state

    assign ctrl_rd = reg_req.rd && (reg_req.addr == lam_pkg::ADDR_ALERT_CTRL);
    assign ctrl_wr = reg_req.wr && (reg_req.addr == lam_pkg::ADDR_ALERT_CTRL);
    assign thr_wr = reg_req.wr && (reg_req.addr == lam_pkg::ADDR_THRESHOLD);
    assign cfg_clr = reg_req.wr && (reg_req.addr == lam_pkg::ADDR_CONFIG)
        && (reg_req.wdata[lam_pkg::MODE_LSB +: lam_pkg::MODE_W]
            != lam_pkg::MODE_POWER_DOWN);
    // Valid only comes after averaging and multiply are finished
    assign done_set = result.valid;
    assign ovf_set = result.valid && result.overflow;
    assign latch = s_q.ctrl[lam_pkg::BIT_LATCH];

    always_comb begin
        s_d = s_q;
        if (ctrl_wr) begin
            s_d.ctrl = (reg_req.wdata & lam_pkg::CTRL_WR_MASK)
                | (s_q.ctrl & ~lam_pkg::CTRL_WR_MASK);
        end
        if (thr_wr) begin
            s_d.thresh = reg_req.wdata;
        end
        // Read snapshot taken before the clear so software sees the flags
        if (reg_req.rd) begin
            case (reg_req.addr)
                lam_pkg::ADDR_ALERT_CTRL: begin
                    s_d.rdata = s_q.ctrl;
                    s_d.rdata[lam_pkg::BIT_SOURCE_FLAG] = s_q.flag_src;
                    s_d.rdata[lam_pkg::BIT_CONV_DONE] = s_q.flag_conv;
                    s_d.rdata[lam_pkg::BIT_OVERFLOW] = s_q.flag_ovf;
                end
                lam_pkg::ADDR_THRESHOLD: begin
                    s_d.rdata = s_q.thresh;
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
        // Done flag: clear first, a coinciding set wins
        if (cfg_clr || ctrl_rd) begin
            s_d.flag_conv = 1'b0;
        end
        if (done_set) begin
            s_d.flag_conv = 1'b1;
        end
        // Source flag
        if (latch) begin
            if (ctrl_rd) begin
                s_d.flag_src = 1'b0;
            end
            if (result.valid && hit) begin
                s_d.flag_src = 1'b1;
            end
        end else if (result.valid) begin
            s_d.flag_src = hit;
        end
        // Overflow follows the latch policy like the source flag
        if (latch) begin
            if (ctrl_rd) begin
                s_d.flag_ovf = 1'b0;
            end
            if (ovf_set) begin
                s_d.flag_ovf = 1'b1;
            end
        end else if (result.valid) begin
            s_d.flag_ovf = result.overflow;
        end
        // Next control word, so the stored alert always matches the stored enables
        s_d.alert = s_d.flag_src
            || (s_d.ctrl[lam_pkg::BIT_CONV_READY] && s_d.flag_conv);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q.ctrl <= lam_pkg::RESET_ALERT_CTRL;
            s_q.thresh <= lam_pkg::RESET_THRESHOLD;
            s_q.rdata <= '0;
            s_q.flag_src <= 1'b0;
            s_q.flag_conv <= 1'b0;
            s_q.flag_ovf <= 1'b0;
            s_q.alert <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = s_q.rdata;
    // Open collector: pull low whenever the pin level should be low, active or idle
    assign alert_out = 1'b0;
    assign alert_oe = s_q.ctrl[lam_pkg::BIT_SENSE_INV] ? !s_q.alert : s_q.alert;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    shunt_over_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_SHUNT_OVER
            && $signed(result.shunt) > $signed(s_q.thresh)) |=> s_q.flag_src)
        else $error("shunt over limit missed");
    priority_sel_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.ctrl[lam_pkg::BIT_SHUNT_OVER] |-> sel == lam_pkg::LAM_SEL_SHUNT_OVER))
        else $error("priority select wrong");
    bus_under_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_BUS_UNDER && !latch
            && result.bus >= s_q.thresh) |=> !s_q.flag_src)
        else $error("bus under false alert");
    done_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl_rd && !result.valid) |=> !s_q.flag_conv)
        else $error("done flag not cleared");
    done_set_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(s_q.flag_conv) |-> $past(result.valid))
        else $error("done flag set without result");
    latch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (latch && s_q.flag_src && !ctrl_rd && !ctrl_wr) |=> s_q.flag_src)
        else $error("latched flag dropped");
    conv_alert_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.ctrl[lam_pkg::BIT_CONV_READY] && s_q.flag_conv) |-> s_q.alert)
        else $error("conversion alert missing");
    polarity_a: assert property (@(posedge clk) disable iff (!rstn)
        alert_oe == (s_q.alert ^ s_q.ctrl[lam_pkg::BIT_SENSE_INV]))
        else $error("alert polarity wrong");
    overflow_a: assert property (@(posedge clk) disable iff (!rstn)
        ovf_set |=> s_q.flag_ovf)
        else $error("overflow flag missed");
    threshold_a: assert property (@(posedge clk) disable iff (!rstn)
        thr_wr |=> s_q.thresh == $past(reg_req.wdata))
        else $error("threshold not stored");

    ////////////////////////////////////////////////////////////////////////
    // Checks of the limit compare

    shunt_under_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_SHUNT_UNDER
            && $signed(result.shunt) < $signed(s_q.thresh)) |=> s_q.flag_src)
        else $error("shunt under limit missed");
    bus_over_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_BUS_OVER
            && result.bus > s_q.thresh) |=> s_q.flag_src)
        else $error("bus over limit missed");
    bus_under_hit_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_BUS_UNDER
            && result.bus < s_q.thresh) |=> s_q.flag_src)
        else $error("bus under limit missed");
    power_over_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_POWER_OVER
            && result.power > s_q.thresh) |=> s_q.flag_src)
        else $error("power over limit missed");
    bus_unsigned_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_BUS_OVER
            && result.bus[lam_pkg::REG_W - 1] && !s_q.thresh[lam_pkg::REG_W - 1])
            |=> s_q.flag_src)
        else $error("bus compared as signed");
    shunt_signed_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && sel == lam_pkg::LAM_SEL_SHUNT_OVER && !latch
            && result.shunt[lam_pkg::REG_W - 1] && !s_q.thresh[lam_pkg::REG_W - 1])
            |=> !s_q.flag_src)
        else $error("shunt compared as unsigned");
    no_limit_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && !latch && sel == lam_pkg::LAM_SEL_NONE) |=> !s_q.flag_src)
        else $error("source flag without limit");
    shunt_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && !latch && sel == lam_pkg::LAM_SEL_SHUNT_OVER
            && $signed(result.shunt) <= $signed(s_q.thresh)) |=> !s_q.flag_src)
        else $error("transparent flag not cleared");

    ////////////////////////////////////////////////////////////////////////
    // Checks of flags, pin and registers

    src_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (latch && ctrl_rd && !result.valid) |=> !s_q.flag_src)
        else $error("latched flag not cleared on read");
    src_snapshot_a: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_rd |=> reg_rdata[lam_pkg::BIT_SOURCE_FLAG] == $past(s_q.flag_src))
        else $error("source flag not reported");
    done_mark_a: assert property (@(posedge clk) disable iff (!rstn)
        result.valid |=> s_q.flag_conv)
        else $error("done flag not set");
    cfg_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (cfg_clr && !result.valid) |=> !s_q.flag_conv)
        else $error("done flag kept after config write");
    ovf_track_a: assert property (@(posedge clk) disable iff (!rstn)
        (result.valid && !latch && !result.overflow) |=> !s_q.flag_ovf)
        else $error("overflow flag stale");
    ovf_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (latch && s_q.flag_ovf && !ctrl_rd && !ctrl_wr) |=> s_q.flag_ovf)
        else $error("latched overflow dropped");
    src_alert_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.flag_src |-> s_q.alert)
        else $error("limit alert not shown");
    idle_release_a: assert property (@(posedge clk) disable iff (!rstn)
        (!s_q.alert && !s_q.ctrl[lam_pkg::BIT_SENSE_INV]) |-> !alert_oe)
        else $error("idle pin pulled low");
    invert_release_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.alert && s_q.ctrl[lam_pkg::BIT_SENSE_INV]) |-> !alert_oe)
        else $error("inverted alert pulled low");
    thresh_read_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == lam_pkg::ADDR_THRESHOLD)
            |=> reg_rdata == $past(s_q.thresh))
        else $error("threshold read wrong");
    thresh_keep_a: assert property (@(posedge clk) disable iff (!rstn)
        !thr_wr |=> $stable(s_q.thresh))
        else $error("threshold changed without write");
    unmapped_read_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr != lam_pkg::ADDR_ALERT_CTRL
            && reg_req.addr != lam_pkg::ADDR_THRESHOLD) |=> reg_rdata == '0)
        else $error("unmapped read not zero");

endmodule

// ===== logic/lam_pkg.sv
// Package for the limit alert monitor: register map, field layout, carriers.
// Assumes a single 50 MHz clock domain and a 16-bit register word.
package lam_pkg;

    localparam int unsigned REG_W = 16;
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_ALERT_CTRL = 8'h06;
    localparam logic [7:0] ADDR_THRESHOLD = 8'h07;
    localparam logic [15:0] RESET_ALERT_CTRL = 16'h0000;
    localparam logic [15:0] RESET_THRESHOLD = 16'h0000;

    // Field positions of the alert control register
    localparam int unsigned BIT_SHUNT_OVER = 15;
    localparam int unsigned BIT_SHUNT_UNDER = 14;
    localparam int unsigned BIT_BUS_OVER = 13;
    localparam int unsigned BIT_BUS_UNDER = 12;
    localparam int unsigned BIT_POWER_OVER = 11;
    localparam int unsigned BIT_CONV_READY = 10;
    localparam int unsigned BIT_SOURCE_FLAG = 4;
    localparam int unsigned BIT_CONV_DONE = 3;
    localparam int unsigned BIT_OVERFLOW = 2;
    localparam int unsigned BIT_SENSE_INV = 1;
    localparam int unsigned BIT_LATCH = 0;
    // Software-writable bits: enables plus polarity and latch
    localparam logic [15:0] CTRL_WR_MASK = 16'hFC03;
    // Operating mode field of the configuration register
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned MODE_W = 2;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h0;

    typedef enum logic [5:0] {
        LAM_SEL_NONE = 6'h01,
        LAM_SEL_SHUNT_OVER = 6'h02,
        LAM_SEL_SHUNT_UNDER = 6'h04,
        LAM_SEL_BUS_OVER = 6'h08,
        LAM_SEL_BUS_UNDER = 6'h10,
        LAM_SEL_POWER_OVER = 6'h20
    } lam_sel_t;

    // New results from the measurement core
    typedef struct packed {
        logic valid;
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] power;
        logic overflow;
    } lam_result_t;

    // Register access strobes from the serial slave engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } lam_reg_req_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] thresh;
        logic [15:0] rdata;
        logic flag_src;
        logic flag_conv;
        logic flag_ovf;
        logic alert;
    } lam_state_t;

endpackage

// ===== test/lam_host.sv
// Host side model: issues register writes and reads as one-cycle strobes.
// Assumes the monitor takes strobes on the rising edge and registers read data.
`timescale 1ns/10ps
module lam_host (
    // Clock
    input wire logic clk,
    // Register strobes
    output lam_pkg::lam_reg_req_t reg_req,
    // Read data
    input wire logic [15:0] reg_rdata
);
    initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 16'hA5A5};
    ////////////////////////////////////////////////////////////////////////////
    // Idle lines show the inverse, so a stale value is never mistaken for data
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        @(negedge clk);
        reg_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge clk);
        q = reg_rdata;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ===== test/lam_monitor_bench.sv
// Bench for the limit alert monitor: drives results, checks flags and pin.
// Assumes lam_host gives register access and the alert pin has a pull-up.
`timescale 1ns/10ps
module lam_monitor_bench;
    logic clk;
    logic rstn;
    lam_pkg::lam_reg_req_t reg_req;
    lam_pkg::lam_result_t result;
    logic [15:0] reg_rdata;
    logic alert_out;
    logic alert_oe;
    logic [15:0] q;
    int n_fail;
    int checked;
    // Pull-up on the open-drain pin
    wire logic alert_pin = alert_oe ? alert_out : 1'b1;
    lam_host u_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    lam_monitor DUT (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .result(result), .alert_in(alert_pin), .alert_out(alert_out), .alert_oe(alert_oe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.access(1'b1, a, d, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        u_host.access(1'b0, a, 16'h0000, q);
        check(q, exp);
    endtask
    task automatic oechk(input logic exp);
        check({15'h0000, alert_oe}, {15'h0000, exp});
        check({15'h0000, alert_pin}, {15'h0000, !exp});
    endtask
    // Extra cycle after valid drops lets the pin settle before sampling
    task automatic put(input logic [15:0] s, input logic [15:0] b, input logic [15:0] p,
                       input logic o);
        @(negedge clk);
        result = '{valid: 1'b1, shunt: s, bus: b, power: p, overflow: o};
        @(negedge clk);
        result = '{valid: 1'b0, shunt: ~s, bus: ~b, power: ~p, overflow: ~o};
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdchk(8'h06, 16'h0000);
        rdchk(8'h07, 16'h0000);
        wr(8'h07, 16'hBEEF);
        rdchk(8'h07, 16'hBEEF);
        wr(8'h06, 16'hFFFF);
        rdchk(8'h06, 16'hFC03);
        rdchk(8'h05, 16'h0000);
        wr(8'h06, 16'h0000);
    endtask
    task automatic t_modes();
        logic [15:0] en;
        logic ov;
        wr(8'h07, 16'h0100);
        for (int i = 0; i < 5; i++) begin
            en = 16'h8000 >> i;
            ov = (i % 2 == 0);
            wr(8'h06, en);
            put(ov ? 16'h0200 : 16'h0050, ov ? 16'h0200 : 16'h0050, ov ? 16'h0200 : 16'h0050,
                1'b0);
            oechk(1'b1);
            put(ov ? 16'h0050 : 16'h0200, ov ? 16'h0050 : 16'h0200, ov ? 16'h0050 : 16'h0200,
                1'b0);
            oechk(1'b0);
            rdchk(8'h06, en | 16'h0008);
        end
    endtask
    task automatic t_signed();
        wr(8'h07, 16'h0010);
        wr(8'h06, 16'h8000);
        put(16'hFFF0, 16'h0000, 16'h0000, 1'b0);
        oechk(1'b0);
        wr(8'h06, 16'h4000);
        put(16'hFFF0, 16'h0000, 16'h0000, 1'b0);
        oechk(1'b1);
        wr(8'h06, 16'h2000);
        put(16'h0000, 16'hFFF0, 16'h0000, 1'b0);
        oechk(1'b1);
    endtask
    task automatic t_prio();
        wr(8'h07, 16'h0100);
        wr(8'h06, 16'h9000);
        put(16'h0050, 16'h0010, 16'h0000, 1'b0);
        oechk(1'b0);
        put(16'h0200, 16'h0010, 16'h0000, 1'b0);
        oechk(1'b1);
    endtask
    task automatic t_latch();
        wr(8'h06, 16'h8403);
        put(16'h0200, 16'h0000, 16'h0000, 1'b1);
        oechk(1'b0);
        put(16'h0050, 16'h0000, 16'h0000, 1'b0);
        oechk(1'b0);
        rdchk(8'h06, 16'h841F);
        rdchk(8'h06, 16'h8403);
        oechk(1'b1);
    endtask
    task automatic t_conv();
        wr(8'h06, 16'h0400);
        put(16'h0000, 16'h0000, 16'h0000, 1'b0);
        oechk(1'b1);
        wr(8'h00, 16'h4124);
        oechk(1'b1);
        wr(8'h00, 16'h4127);
        oechk(1'b0);
        put(16'h0000, 16'h0000, 16'h0000, 1'b0);
        rdchk(8'h06, 16'h0408);
        oechk(1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        n_fail = 0;
        checked = 0;
        result = '0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        t_regs();
        t_modes();
        t_signed();
        t_prio();
        t_latch();
        t_conv();
        close_out();
    end
    // Whole run needs about 125 cycles; this bound is generous
    initial begin
        #200us;
        n_fail++;
        close_out();
    end
endmodule
